/* File: inc/fpid_pkg.sv */
`default_nettype none
package fpid_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_DEEP_SLEEP   = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID      = 8'hab;
  localparam logic [7:0] OP_ID_SINGLE    = 8'h90;
  localparam logic [7:0] OP_ID_DUAL      = 8'h92;
  localparam logic [7:0] OP_ID_QUAD      = 8'h94;
  localparam logic [7:0] OP_HIGH_SPEED   = 8'ha3;
  // rising serial clock counts within a frame
  localparam logic [7:0] CLK_ONE       = 8'h01;
  localparam logic [7:0] CLK_SAT       = 8'hff;
  localparam logic [7:0] CLK_OP        = 8'h08;
  localparam logic [7:0] CLK_ADDR_ONE  = 8'h20;
  localparam logic [7:0] CLK_ADDR_DUAL = 8'h14;
  localparam logic [7:0] CLK_ADDR_QUAD = 8'h0e;
  localparam logic [7:0] CLK_ID_QUAD   = 8'h12;
  localparam logic [7:0] CLK_WAKE_ID   = 8'h20;
  // io lanes
  localparam logic [2:0] LANES_ONE  = 3'h1;
  localparam logic [2:0] LANES_DUAL = 3'h2;
  localparam logic [2:0] LANES_QUAD = 3'h4;
  // protect field
  localparam int unsigned PROT_W      = 5;
  localparam int unsigned PROT_SECTOR = 4;
  localparam int unsigned PROT_BOTTOM = 3;
  localparam logic [2:0]  BP_NONE     = 3'h0;
  localparam logic [2:0]  BP_ALL      = 3'h7;
  localparam int unsigned ADDR_BLK_LSB = 16;
  // timing
  localparam int unsigned SYS_CLK_MHZ            = 125;
  localparam int unsigned TIMER_W                = 32;
  localparam int unsigned BLOCK_ERASE_TIME_US    = 1000;
  localparam int unsigned ARRAY_ERASE_TIME_US    = 20000;
  localparam int unsigned SLEEP_ENTRY_DELAY_NS   = 3000;
  localparam int unsigned WAKE_DELAY_NS          = 3000;
  localparam int unsigned WAKE_WITH_ID_DELAY_NS  = 3000;
  localparam int unsigned BLOCK_ERASE_CYC =
    BLOCK_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned ARRAY_ERASE_CYC =
    ARRAY_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC =
    (WAKE_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_ID_CYC =
    (WAKE_WITH_ID_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_BLOCK_ERASE, ST_ARRAY_ERASE, ST_SLEEP_ENTRY, ST_WAKE
  } fpid_state_t;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  clocks;
  } fpid_frame_t;
  typedef struct packed {
    logic busy;
    logic asleep;
    logic waking;
  } fpid_gate_t;
endpackage
`default_nettype wire

/* File: rtl/fpid_core.sv */
`timescale 1ns/1ps
`default_nettype none
module fpid_core #(
  parameter int unsigned BLK_W           = 7,
  parameter logic [7:0]  MFR_ID          = 8'h5a, // arbitrary value
  parameter logic [7:0]  DEV_ID          = 8'h17, // arbitrary value
  parameter int unsigned BLOCK_ERASE_CYC = fpid_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned ARRAY_ERASE_CYC = fpid_pkg::ARRAY_ERASE_CYC
) (
  // system
  input  wire logic                        sys_clk_i,
  input  wire logic                        nrst_i,
  // serial link
  input  wire logic                        spi_clk_i,
  input  wire logic                        spi_cs_n_i,
  input  wire logic [3:0]                  spi_io_i,
  output var  logic [3:0]                  spi_io_o,
  output var  logic [3:0]                  spi_io_oe_o,
  // protection settings
  input  wire logic [fpid_pkg::PROT_W-1:0] protect_select_i,
  input  wire logic                        protect_invert_bit_i,
  // status
  output var  logic                        op_in_progress_flag_o,
  output var  logic                        write_latch_flag_o,
  output var  logic                        deep_sleep_o,
  output var  logic                        high_speed_mode_o,
  // erase request to the array
  output var  logic                        erase_start_o,
  output var  logic                        erase_chip_o,
  output var  logic [BLK_W-1:0]            erase_block_o
);
  localparam int unsigned TW = fpid_pkg::TIMER_W;

  function automatic logic [2:0] op_lanes(input logic [7:0] op);
    op_lanes = (op == fpid_pkg::OP_ID_QUAD) ? fpid_pkg::LANES_QUAD :
               (op == fpid_pkg::OP_ID_DUAL) ? fpid_pkg::LANES_DUAL :
               fpid_pkg::LANES_ONE;
  endfunction

  function automatic logic [7:0] op_addr_end(input logic [7:0] op);
    op_addr_end = (op == fpid_pkg::OP_ID_QUAD) ? fpid_pkg::CLK_ADDR_QUAD :
                  (op == fpid_pkg::OP_ID_DUAL) ? fpid_pkg::CLK_ADDR_DUAL :
                  fpid_pkg::CLK_ADDR_ONE;
  endfunction

  function automatic logic [7:0] op_id_start(input logic [7:0] op);
    op_id_start = (op == fpid_pkg::OP_ID_QUAD) ? fpid_pkg::CLK_ID_QUAD :
                  (op == fpid_pkg::OP_ID_DUAL) ? fpid_pkg::CLK_ADDR_DUAL :
                  (op == fpid_pkg::OP_WAKE_ID) ? fpid_pkg::CLK_WAKE_ID :
                  fpid_pkg::CLK_ADDR_ONE;
  endfunction

  // bp[2:0] sizes a top or bottom region; sector mode guards one block unless bp[2:0] is zero (none) or all ones (all)
  function automatic logic blk_protected(input logic [BLK_W-1:0] blk,
                                         input logic [4:0]       bp,
                                         input logic             inv);
    logic [BLK_W:0] b;
    logic [BLK_W:0] sz;
    logic [BLK_W:0] nb;
    logic           hit;
    b   = {1'b0, blk};
    nb  = {1'b1, {BLK_W{1'b0}}};
    sz  = {{BLK_W{1'b0}}, 1'b1};
    hit = 1'b0;
    if (bp[2:0] == fpid_pkg::BP_ALL) begin
      hit = 1'b1;
    end else if (bp[2:0] != fpid_pkg::BP_NONE) begin
      if (!bp[fpid_pkg::PROT_SECTOR]) begin
        sz = sz << (bp[2:0] - 3'h1);
      end
      hit = bp[fpid_pkg::PROT_BOTTOM] ? (b < sz) : (b >= nb - sz);
    end
    blk_protected = hit ^ inv;
  endfunction

  // ---------------- link domain ----------------
  wire link_rst;
  wire link_nrst_hold;
  assign link_rst       = spi_cs_n_i | ~nrst_i;
  assign link_nrst_hold = ~nrst_i;

  logic                  first_r;
  logic                  tgl_r;
  fpid_pkg::fpid_frame_t frm_r;
  fpid_pkg::fpid_frame_t frm_nxt;
  fpid_pkg::fpid_gate_t  gmeta_r;
  fpid_pkg::fpid_gate_t  gsync_r;
  fpid_pkg::fpid_gate_t  gate_r;
  logic [3:0]            out_idx_r;
  logic [3:0]            io_o_r;
  logic [3:0]            io_oe_r;

  wire [7:0]  clk_cnt;
  wire        op_shift;
  wire        addr_shift;
  wire [2:0]  lanes;
  wire [3:0]  lane_mask;
  wire [23:0] addr_in;
  wire        wake_kind;
  wire        id_kind;
  wire        id_ok;
  wire        data_on;
  wire [15:0] pat;
  wire [15:0] pat_sh;
  wire [3:0]  top;
  wire [3:0]  io_o_nxt;
  wire [3:0]  io_oe_nxt;

  assign lanes     = op_lanes(frm_r.op);
  assign lane_mask = 4'((5'h01 << lanes) - 5'h01);
  assign clk_cnt   = first_r ? fpid_pkg::CLK_ONE :
                     (frm_r.clocks == fpid_pkg::CLK_SAT) ? frm_r.clocks :
                     frm_r.clocks + 8'h01;
  assign op_shift  = first_r || (frm_r.clocks < fpid_pkg::CLK_OP);
  assign addr_shift = !first_r && (frm_r.clocks >= fpid_pkg::CLK_OP) &&
                      (frm_r.clocks < op_addr_end(frm_r.op));
  assign addr_in   = (frm_r.addr << lanes) |
                     {20'h00000, spi_io_i & lane_mask};
  assign frm_nxt.op     = op_shift ? {frm_r.op[6:0], spi_io_i[0]} :
                          frm_r.op;
  assign frm_nxt.addr   = addr_shift ? addr_in : frm_r.addr;
  assign frm_nxt.clocks = clk_cnt;

  // frame words stay put after the last edge; the system side reads them
  // only once the synchronised chip select shows the frame closed
  always_ff @(posedge spi_clk_i or posedge link_nrst_hold) begin
    if (link_nrst_hold) begin
      frm_r <= '0;
      tgl_r <= 1'b0;
    end else begin
      frm_r <= frm_nxt;
      tgl_r <= tgl_r ^ first_r;
    end
  end

  always_ff @(posedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      first_r <= 1'b1;
      gmeta_r <= '1;
      gsync_r <= '1;
    end else begin
      first_r <= 1'b0;
      gmeta_r <= gate_r;
      gsync_r <= gmeta_r;
    end
  end

  assign wake_kind = frm_r.op == fpid_pkg::OP_WAKE_ID;
  assign id_kind   = (frm_r.op == fpid_pkg::OP_ID_SINGLE) ||
                     (frm_r.op == fpid_pkg::OP_ID_DUAL) ||
                     (frm_r.op == fpid_pkg::OP_ID_QUAD);
  assign id_ok = (wake_kind && !gsync_r.busy && !gsync_r.waking) ||
                 (id_kind && !gsync_r.asleep && !gsync_r.waking &&
                  ((frm_r.addr >> 1) == 24'h000000));
  assign data_on = !first_r && id_ok &&
                   (frm_r.clocks >= op_id_start(frm_r.op));
  assign pat = wake_kind ? {DEV_ID, DEV_ID} :
               frm_r.addr[0] ? {DEV_ID, MFR_ID} :
               {MFR_ID, DEV_ID};
  assign pat_sh = pat << out_idx_r;
  assign top    = pat_sh[15:12];
  assign io_o_nxt  = (lanes == fpid_pkg::LANES_QUAD) ? top :
                     (lanes == fpid_pkg::LANES_DUAL) ? (top >> 2) :
                     {2'b00, top[3], 1'b0};
  assign io_oe_nxt = data_on ? (lane_mask == 4'h1 ? 4'h2 : lane_mask) :
                     4'h0;

  // ids leave on falling edges; the index wraps so the pair repeats
  always_ff @(negedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      out_idx_r <= 4'h0;
      io_o_r    <= 4'h0;
      io_oe_r   <= 4'h0;
    end else begin
      out_idx_r <= data_on ? out_idx_r + {1'b0, lanes} : 4'h0;
      io_o_r    <= data_on ? io_o_nxt : 4'h0;
      io_oe_r   <= io_oe_nxt;
    end
  end

  assign spi_io_o    = io_o_r;
  assign spi_io_oe_o = io_oe_r;

  // ---------------- system domain ----------------
  logic                  cs_meta_r;
  logic                  cs_sync_r;
  logic                  cs_prev_r;
  logic                  tg_meta_r;
  logic                  tg_sync_r;
  logic                  tg_seen_r;
  fpid_pkg::fpid_state_t state_r;
  fpid_pkg::fpid_state_t state_nxt;
  logic [TW-1:0]         timer_r;
  logic [TW-1:0]         timer_nxt;
  logic                  busy_r;
  logic                  wel_r;
  logic                  sleep_r;
  logic                  hpm_r;
  logic                  erase_start_r;
  logic                  erase_chip_r;
  logic [BLK_W-1:0]      erase_block_r;

  wire             frame_end;
  wire             evt;
  wire [7:0]       op;
  wire [7:0]       clk;
  wire [BLK_W-1:0] blk;
  wire             idle;
  wire             waking;
  wire             tmr_zero;
  wire             awake_ok;
  wire             chip_ok;
  wire             abh_form;
  wire             go_write_enable_cmd;
  wire             go_blk;
  wire             go_chip;
  wire             go_sleep;
  wire             go_wake;
  wire             go_hpm_off;
  wire             go_hpm;
  wire             erase_done;
  wire [TW-1:0]    wake_load;

  assign frame_end = cs_sync_r & ~cs_prev_r;
  assign evt       = frame_end & (tg_sync_r ^ tg_seen_r);
  assign op        = frm_r.op;
  assign clk       = frm_r.clocks;
  assign blk       = frm_r.addr[fpid_pkg::ADDR_BLK_LSB +: BLK_W];
  assign idle      = state_r == fpid_pkg::ST_IDLE;
  assign waking    = state_r == fpid_pkg::ST_WAKE;
  assign tmr_zero  = timer_r == '0;
  // idle excludes running cycles, wake delay and sleep entry
  assign awake_ok  = evt & idle & ~sleep_r;
  assign chip_ok   =
    ((protect_select_i[2:0] == fpid_pkg::BP_NONE) & ~protect_invert_bit_i) |
    ((protect_select_i[2:0] == fpid_pkg::BP_ALL) & protect_invert_bit_i);
  assign abh_form  = (op == fpid_pkg::OP_WAKE_ID) &
                     ((clk == fpid_pkg::CLK_OP) |
                      (clk >= fpid_pkg::CLK_WAKE_ID));
  assign go_write_enable_cmd   = awake_ok & (op == fpid_pkg::OP_WRITE_ENABLE) &
                     (clk == fpid_pkg::CLK_OP);
  assign go_blk    = awake_ok & wel_r &
                     (op == fpid_pkg::OP_BLOCK_ERASE) &
                     (clk == fpid_pkg::CLK_ADDR_ONE) &
                     ~blk_protected(blk, protect_select_i,
                                    protect_invert_bit_i);
  assign go_chip   = awake_ok & wel_r & chip_ok &
                     ((op == fpid_pkg::OP_CHIP_ERASE_A) |
                      (op == fpid_pkg::OP_CHIP_ERASE_B)) &
                     (clk == fpid_pkg::CLK_OP);
  assign go_sleep  = awake_ok & (op == fpid_pkg::OP_DEEP_SLEEP) &
                     (clk == fpid_pkg::CLK_OP);
  assign go_wake   = evt & idle & sleep_r & abh_form;
  assign go_hpm_off = evt & ~busy_r & ~waking & ~sleep_r & abh_form;
  assign go_hpm    = awake_ok & (op == fpid_pkg::OP_HIGH_SPEED) &
                     (clk == fpid_pkg::CLK_ADDR_ONE);
  assign erase_done = busy_r & tmr_zero;
  assign wake_load = (clk == fpid_pkg::CLK_OP) ?
                     TW'(fpid_pkg::WAKE_CYC - 1) :
                     TW'(fpid_pkg::WAKE_ID_CYC - 1);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = tmr_zero ? timer_r : timer_r - TW'(1);
    unique case (state_r)
      fpid_pkg::ST_IDLE: begin
        if (go_blk) begin
          state_nxt = fpid_pkg::ST_BLOCK_ERASE;
          timer_nxt = TW'(BLOCK_ERASE_CYC - 1);
        end else if (go_chip) begin
          state_nxt = fpid_pkg::ST_ARRAY_ERASE;
          timer_nxt = TW'(ARRAY_ERASE_CYC - 1);
        end else if (go_sleep) begin
          state_nxt = fpid_pkg::ST_SLEEP_ENTRY;
          timer_nxt = TW'(fpid_pkg::SLEEP_ENTRY_CYC - 1);
        end else if (go_wake) begin
          state_nxt = fpid_pkg::ST_WAKE;
          timer_nxt = wake_load;
        end
      end
      fpid_pkg::ST_SLEEP_ENTRY: begin
        if (go_hpm_off || tmr_zero) begin
          state_nxt = fpid_pkg::ST_IDLE;
        end
      end
      fpid_pkg::ST_BLOCK_ERASE,
      fpid_pkg::ST_ARRAY_ERASE,
      fpid_pkg::ST_WAKE: begin
        if (tmr_zero) begin
          state_nxt = fpid_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      tg_meta_r <= 1'b0;
      tg_sync_r <= 1'b0;
      tg_seen_r <= 1'b0;
    end else begin
      cs_meta_r <= spi_cs_n_i;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      tg_meta_r <= tgl_r;
      tg_sync_r <= tg_meta_r;
      tg_seen_r <= frame_end ? tg_sync_r : tg_seen_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_r       <= fpid_pkg::ST_IDLE;
      timer_r       <= '0;
      busy_r        <= 1'b0;
      wel_r         <= 1'b0;
      sleep_r       <= 1'b0;
      hpm_r         <= 1'b0;
      erase_start_r <= 1'b0;
      erase_chip_r  <= 1'b0;
      erase_block_r <= '0;
      gate_r        <= '0;
    end else begin
      state_r       <= state_nxt;
      timer_r       <= timer_nxt;
      busy_r        <= go_blk | go_chip | (busy_r & ~tmr_zero);
      wel_r         <= go_write_enable_cmd | (wel_r & ~(go_blk | go_chip));
      sleep_r       <= ((state_r == fpid_pkg::ST_SLEEP_ENTRY) & tmr_zero &
                        ~go_hpm_off) | (sleep_r & ~go_wake);
      hpm_r         <= go_hpm | (hpm_r & ~(go_sleep | go_hpm_off));
      erase_start_r <= go_blk | go_chip;
      erase_chip_r  <= go_chip | (erase_chip_r & ~go_blk);
      erase_block_r <= go_blk ? blk : erase_block_r;
      gate_r.busy   <= busy_r;
      gate_r.asleep <= sleep_r;
      gate_r.waking <= waking;
    end
  end

  assign op_in_progress_flag_o = busy_r;
  assign write_latch_flag_o    = wel_r;
  assign deep_sleep_o          = sleep_r;
  assign high_speed_mode_o     = hpm_r;
  assign erase_start_o         = erase_start_r;
  assign erase_chip_o          = erase_chip_r;
  assign erase_block_o         = erase_block_r;

  a_erase_latch_used: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) $rose(busy_r) |-> $past(wel_r) && !wel_r)
    else $error("erase started without write latch or latch kept");

  a_block_busy_hold: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    erase_start_r && !erase_chip_r |-> busy_r [*8])
    else $error("busy dropped early in block erase");

  a_block_frame_ok: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) erase_start_r && !erase_chip_r |->
    $past(clk) == fpid_pkg::CLK_ADDR_ONE &&
    $past(op) == fpid_pkg::OP_BLOCK_ERASE)
    else $error("block erase from a malformed frame");

  a_block_unprot: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) erase_start_r && !erase_chip_r |->
    !blk_protected(erase_block_r, $past(protect_select_i),
                   $past(protect_invert_bit_i)))
    else $error("protected block erased");

  a_chip_prot_ok: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) erase_start_r && erase_chip_r |->
    $past(chip_ok) && $past(clk) == fpid_pkg::CLK_OP)
    else $error("chip erase with protection or bad frame");

  a_sleep_after_delay: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) $rose(sleep_r) |->
    $past(state_r) == fpid_pkg::ST_SLEEP_ENTRY && $past(tmr_zero))
    else $error("deep sleep entered without entry delay");

  a_sleep_no_write: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) $past(sleep_r) && sleep_r |->
    !$rose(wel_r) && !$rose(busy_r) && !$rose(hpm_r))
    else $error("command honoured in deep sleep");

  a_sleep_busy_rej: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    busy_r |=> state_r != fpid_pkg::ST_SLEEP_ENTRY)
    else $error("sleep entry while cycle runs");

  a_wake_quiet: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) $fell(sleep_r) |->
    !busy_r [*2] ##0 state_r == fpid_pkg::ST_WAKE)
    else $error("release without wake delay");

  a_abh_busy_ign: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i) $past(busy_r) && busy_r |-> !$fell(hpm_r))
    else $error("release honoured while busy");
endmodule
`default_nettype wire

/* File: bench/fpid_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the link; serial clock idles low between frames
module fpid_host (
  // serial link
  output var  logic       spi_clk_o,
  output var  logic       spi_cs_n_o,
  output var  logic [3:0] spi_io_o,
  input  wire logic [3:0] spi_io_i
);
  initial begin
    spi_clk_o  = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_io_o   = 4'h0;
  end
  // opcode goes out msb first on io0, then the address on ln lanes; n sets
  // the exact clock count, ids are read once address and dummies are in
  task automatic frame(input logic [31:0] word, input int ln, input int n,
                       output logic [15:0] rd);
    int start;
    rd    = 16'h0;
    start = (ln == 4) ? 18 : (ln == 2) ? 20 : 32;
    #3;
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (ln == 1 || i < 8) begin
        // unused lanes toggle so nothing stale is read back
        spi_io_o = {~spi_io_o[3:1], (i < 32) ? word[31-i] : i[0]};
      end else if (ln * (i - 7) <= 24) begin
        spi_io_o = 4'((word[23:0] << (ln * (i - 8))) >> (24 - ln));
      end else begin
        spi_io_o = ~spi_io_o;
      end
      #24;
      if (i >= start) begin
        rd = (ln == 4) ? {rd[11:0], spi_io_i} :
             (ln == 2) ? {rd[13:0], spi_io_i[1:0]} :
             {rd[14:0], spi_io_i[1]};
      end
      spi_clk_o = 1'b1;
      #24;
      spi_clk_o = 1'b0;
    end
    #24;
    spi_cs_n_o = 1'b1;
    spi_io_o   = ~spi_io_o;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        spi_clk;
  logic        spi_cs_n;
  logic [3:0]  host_io;
  logic [3:0]  dev_io;
  logic [3:0]  dev_oe;
  logic [3:0]  io_w;
  logic [4:0]  prot    = 5'h00;
  logic        inv     = 1'b0;
  logic        busy;
  logic        write_latch_flag;
  logic        asleep;
  logic        hsm;
  logic        e_chip;
  logic        e_start;
  logic [6:0]  e_blk;
  logic [15:0] rd;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          start_cnt       = 0;

  assign io_w = (dev_oe & dev_io) | (~dev_oe & host_io);
  always #4 sys_clk = ~sys_clk;

  // short erase counts keep the run brief
  fpid_core #(.BLOCK_ERASE_CYC(400), .ARRAY_ERASE_CYC(800),
              .MFR_ID(8'h3c), .DEV_ID(8'hc5)) fpid_core_i (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .spi_clk_i(spi_clk),
    .spi_cs_n_i(spi_cs_n), .spi_io_i(io_w), .spi_io_o(dev_io),
    .spi_io_oe_o(dev_oe), .protect_select_i(prot),
    .protect_invert_bit_i(inv), .op_in_progress_flag_o(busy),
    .write_latch_flag_o(write_latch_flag), .deep_sleep_o(asleep),
    .high_speed_mode_o(hsm), .erase_start_o(e_start), .erase_chip_o(e_chip),
    .erase_block_o(e_blk));
  fpid_host fpid_host_i (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n),
    .spi_io_o(host_io), .spi_io_i(io_w));

  // one pulse per accepted erase, counted where it is settled
  always @(negedge sys_clk) begin
    if (e_start === 1'b1) begin
      start_cnt++;
    end
  end

  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmd_lanes(input logic [31:0] w, input int ln, input int n);
    fpid_host_i.frame(w, ln, n, rd);
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic cmd(input logic [31:0] w, input int n);
    cmd_lanes(w, 1, n);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk(busy, 32'h0);
  endtask
  task automatic t_block;
    cmd({8'hd8, 24'h130000}, 32);
    chk(busy, 32'h0);
    cmd(32'h06000000, 8);
    chk(write_latch_flag, 32'h1);
    cmd({8'hd8, 24'h13abcd}, 31);
    chk({busy, write_latch_flag}, 32'h1);
    cmd(32'ha3000000, 32);
    cmd({8'hd8, 24'h13abcd}, 32);
    chk({busy, write_latch_flag, e_chip, e_blk}, {22'h0, 3'b100, 7'h13});
    chk(start_cnt, 32'h1);
    cmd(32'hab000000, 8);
    chk({busy, hsm}, 32'h3);
    cmd(32'hb9000000, 8);
    wait_idle();
    repeat (400) @(negedge sys_clk);
    chk(asleep, 32'h0);
  endtask
  task automatic t_protect;
    prot = 5'h07;
    cmd(32'h06000000, 8);
    cmd({8'hd8, 24'h010000}, 32);
    chk(busy, 32'h0);
    cmd(32'h60000000, 8);
    chk(busy, 32'h0);
    inv = 1'b1;
    cmd(32'hc7000000, 8);
    chk({busy, write_latch_flag, e_chip}, 32'h5);
    wait_idle();
    prot = 5'h00;
    inv  = 1'b0;
    cmd(32'h06000000, 8);
    cmd(32'h60000000, 8);
    chk({busy, e_chip}, 32'h3);
    wait_idle();
    chk(start_cnt, 32'h3);
  endtask
  task automatic t_id;
    cmd({8'h90, 24'h000000}, 48);
    chk(rd, 32'h3cc5);
    cmd({8'h90, 24'h000001}, 48);
    chk(rd, 32'hc53c);
    cmd({8'hab, 24'h000000}, 48);
    chk(rd, 32'hc5c5);
    cmd_lanes({8'h92, 24'h000000}, 2, 28);
    chk(rd, 32'h3cc5);
    cmd_lanes({8'h92, 24'h000001}, 2, 28);
    chk(rd, 32'hc53c);
    cmd_lanes({8'h94, 24'h000000}, 4, 22);
    chk(rd, 32'h3cc5);
    cmd_lanes({8'h94, 24'h000001}, 4, 22);
    chk(rd, 32'hc53c);
  endtask
  task automatic t_sleep;
    cmd(32'ha3000000, 32);
    chk(hsm, 32'h1);
    cmd(32'hb9000000, 8);
    chk(asleep, 32'h0);
    repeat (400) @(negedge sys_clk);
    chk(asleep, 32'h1);
    cmd(32'h06000000, 8);
    chk(write_latch_flag, 32'h0);
    cmd(32'hab000000, 8);
    chk(asleep, 32'h0);
    cmd(32'h06000000, 8);
    chk(write_latch_flag, 32'h0);
    repeat (400) @(negedge sys_clk);
    cmd(32'h06000000, 8);
    chk(write_latch_flag, 32'h1);
    cmd(32'ha3000000, 32);
    cmd(32'hab000000, 8);
    chk(hsm, 32'h0);
    cmd(32'hb9000000, 8);
    repeat (400) @(negedge sys_clk);
    cmd({8'hab, 24'h000000}, 48);
    chk({asleep, rd}, 32'hc5c5);
    cmd(32'ha3000000, 32);
    chk(hsm, 32'h0);
    repeat (400) @(negedge sys_clk);
    cmd(32'ha3000000, 32);
    chk(hsm, 32'h1);
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({busy, write_latch_flag, asleep, hsm}, 32'h0);
    t_block();
    t_protect();
    t_id();
    t_sleep();
    give_verdict();
  end
  // the tests need roughly seventy microseconds
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
